//--- src/dvmc_top.sv
// Purpose: velocity operating modes of an integrated drive
// Assumes: parameter port driven by fieldbus logic on i_sys_clk
// Notes: halt, quick stop and fault come from the common drive logic
//
// What this block and its master do
// R1: opmode write switches mode at once
// R2: master sets speed source to 2 first
// R3: source 0 is none, 2 is parameter
// R4: speed reference write starts speed movement
// R5: speed control applies reference without ramp
// R6: master keeps control bits 4-6 zero
// R7: speed control: status bits 10, 12 reserved
// R8: leave mode on standstill after stop cause
// R9: speed reference signed 16, +-30000, reset 0
// R10: speed command clamped to maximum speed
// R11: profile velocity ramps toward target
// R12: profile target write starts movement
// R13: profile: bit 10 marks target reached
// R14: profile: bit 12 marks zero velocity
// R15: profile target clamped to both ceilings
// R16: movement starts only over the fieldbus
`timescale 1ns/100ps
module dvmc_top #(
  parameter int RAMP_TICK_CYCLES = dvmc_pkg::RAMP_TICK_CYCLES,
  parameter logic [15:0] RAMP_STEP_RPM = dvmc_pkg::RAMP_STEP_RPM
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // fieldbus parameter access
  input wire logic i_par_wr,
  input wire logic i_par_rd,
  input wire logic [15:0] i_par_addr,
  input wire logic [31:0] i_par_wdata,
  output logic [31:0] o_par_rdata,
  output logic o_par_rvalid,
  // drive context
  input wire logic i_halt,
  input wire logic i_quick_stop,
  input wire logic i_fault,
  input wire logic signed [31:0] i_actual_velocity,
  input wire logic [15:0] i_max_speed,
  input wire logic [15:0] i_ramp_velocity_ceiling,
  // results
  output logic signed [31:0] o_vel_cmd,
  output logic [15:0] o_drive_status_word,
  output logic [1:0] o_active_mode
);

  // ************************************************************
  // state
  // ************************************************************
  dvmc_pkg::dvmc_state_type state;
  dvmc_pkg::dvmc_state_type next_state;
  logic [15:0] operating_mode_select;
  logic [15:0] next_operating_mode_select;
  logic [15:0] speed_ref_source;
  logic [15:0] next_speed_ref_source;
  logic [15:0] speed_ref_velocity;
  logic [15:0] next_speed_ref_velocity;
  logic [31:0] profile_target_velocity;
  logic [31:0] next_profile_target_velocity;
  logic moving;
  logic next_moving;
  logic [31:0] par_rdata;
  logic [31:0] next_par_rdata;
  logic par_rvalid;
  logic [15:0] status_word;
  logic [15:0] next_status_word;
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic tick;

  logic stop_req;
  logic active;
  logic opm_wr;
  logic spd_ok;
  logic [15:0] pv_lim;
  logic signed [31:0] speed_target;
  logic signed [31:0] pv_target_lim;
  logic signed [31:0] cmd_target;

  function automatic logic signed [31:0] clamp_vel(input logic signed [31:0] v,
                                                   input logic [15:0] lim);
    logic signed [31:0] hi;
    hi = $signed({16'h0000, lim});
    if (v > hi)
      return hi;
    if (v < -hi)
      return -hi;
    return v;
  endfunction

  assign stop_req = i_halt | i_quick_stop | i_fault;
  assign active = (state == dvmc_pkg::VM_SPEED) || (state == dvmc_pkg::VM_PROFILE);
  assign opm_wr = i_par_wr && (i_par_addr == dvmc_pkg::ADDR_OPMODE);
  assign spd_ok = ($signed(i_par_wdata[15:0]) >= $signed(dvmc_pkg::SPEED_REF_MIN))
               && ($signed(i_par_wdata[15:0]) <= $signed(dvmc_pkg::SPEED_REF_MAX)); // R9

  // ************************************************************
  // command target
  // ************************************************************
  always_comb
  begin
    pv_lim = (i_max_speed < i_ramp_velocity_ceiling) ? i_max_speed : i_ramp_velocity_ceiling;
    pv_target_lim = clamp_vel($signed(profile_target_velocity), pv_lim); // R15
    speed_target = 32'sh0000_0000;
    // source none gives a zero command, the motor is held still
    if (moving && (speed_ref_source == dvmc_pkg::SRC_PARAM)) // R3
      speed_target = clamp_vel(32'($signed(speed_ref_velocity)), i_max_speed); // R10
    cmd_target = 32'sh0000_0000;
    if (state == dvmc_pkg::VM_SPEED)
      cmd_target = speed_target;
    else if ((state == dvmc_pkg::VM_PROFILE) && moving)
      cmd_target = pv_target_lim; // R11
  end

  // ************************************************************
  // ramp tick divider
  // ************************************************************
  always_comb
  begin
    tick = (tick_cnt == 32'(RAMP_TICK_CYCLES - 1));
    next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      tick_cnt <= 32'h0000_0000;
    else
      tick_cnt <= next_tick_cnt;
  end

  dvmc_ramp #(
    .STEP(RAMP_STEP_RPM)
  ) dvmc_ramp_i (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_tick(tick),
    .i_bypass(state == dvmc_pkg::VM_SPEED), // R5
    .i_target(cmd_target),
    .o_vel(o_vel_cmd)
  );

  // ************************************************************
  // mode and parameter writes
  // ************************************************************
  always_comb
  begin
    next_state = state;
    next_moving = moving;
    next_operating_mode_select = operating_mode_select;
    next_speed_ref_source = speed_ref_source;
    next_speed_ref_velocity = speed_ref_velocity;
    next_profile_target_velocity = profile_target_velocity;
    if (active && stop_req)
    begin
      next_moving = 1'b0;
      if (i_actual_velocity == 32'sh0000_0000)
        next_state = dvmc_pkg::VM_IDLE; // R8
    end
    if (opm_wr)
    begin
      // a mode write always wins and drops any running movement
      next_operating_mode_select = i_par_wdata[15:0];
      next_moving = 1'b0;
      if (i_par_wdata[15:0] == dvmc_pkg::OPMODE_SPEED_CTRL)
        next_state = dvmc_pkg::VM_SPEED; // R1
      else if (i_par_wdata[15:0] == dvmc_pkg::OPMODE_PROFILE_VEL)
        next_state = dvmc_pkg::VM_PROFILE; // R1
      else
        next_state = dvmc_pkg::VM_IDLE;
    end
    else if (i_par_wr && (i_par_addr == dvmc_pkg::ADDR_SPEED_SOURCE))
    begin
      if ((i_par_wdata[15:0] == dvmc_pkg::SRC_NONE)
          || (i_par_wdata[15:0] == dvmc_pkg::SRC_PARAM))
        next_speed_ref_source = i_par_wdata[15:0]; // R3
    end
    else if (i_par_wr && (i_par_addr == dvmc_pkg::ADDR_SPEED_REF) && spd_ok)
    begin
      next_speed_ref_velocity = i_par_wdata[15:0]; // R9
      if ((state == dvmc_pkg::VM_SPEED) && !stop_req)
        next_moving = 1'b1; // R4 R16
    end
    else if (i_par_wr && (i_par_addr == dvmc_pkg::ADDR_PROFILE_TARGET))
    begin
      next_profile_target_velocity = i_par_wdata; // R15
      if ((state == dvmc_pkg::VM_PROFILE) && !stop_req)
        next_moving = 1'b1; // R12 R16
    end
  end

  // ************************************************************
  // status word and read back
  // ************************************************************
  always_comb
  begin
    next_status_word = 16'h0000; // R7
    if (state == dvmc_pkg::VM_PROFILE)
    begin
      next_status_word[dvmc_pkg::STAT_REACHED_BIT] = (i_actual_velocity == cmd_target); // R13
      next_status_word[dvmc_pkg::STAT_ZERO_BIT] = (i_actual_velocity == 32'sh0000_0000); // R14
    end
    next_par_rdata = 32'h0000_0000;
    if (i_par_rd)
    begin
      if (i_par_addr == dvmc_pkg::ADDR_OPMODE)
        next_par_rdata = {16'h0000, operating_mode_select};
      else if (i_par_addr == dvmc_pkg::ADDR_SPEED_SOURCE)
        next_par_rdata = {16'h0000, speed_ref_source};
      else if (i_par_addr == dvmc_pkg::ADDR_SPEED_REF)
        next_par_rdata = {16'h0000, speed_ref_velocity};
      else if (i_par_addr == dvmc_pkg::ADDR_PROFILE_TARGET)
        next_par_rdata = profile_target_velocity;
      else if (i_par_addr == dvmc_pkg::ADDR_STATUS)
        next_par_rdata = {16'h0000, status_word};
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      state <= dvmc_pkg::VM_IDLE;
      moving <= 1'b0;
      operating_mode_select <= dvmc_pkg::RST_OPMODE;
      speed_ref_source <= dvmc_pkg::RST_SPEED_SOURCE;
      speed_ref_velocity <= dvmc_pkg::RST_SPEED_REF;
      profile_target_velocity <= dvmc_pkg::RST_PROFILE_TARGET;
      status_word <= 16'h0000;
      par_rdata <= 32'h0000_0000;
      par_rvalid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      moving <= next_moving;
      operating_mode_select <= next_operating_mode_select;
      speed_ref_source <= next_speed_ref_source;
      speed_ref_velocity <= next_speed_ref_velocity;
      profile_target_velocity <= next_profile_target_velocity;
      status_word <= next_status_word;
      par_rdata <= next_par_rdata;
      par_rvalid <= i_par_rd;
    end
  end

  assign o_par_rdata = par_rdata;
  assign o_par_rvalid = par_rvalid;
  assign o_drive_status_word = status_word;
  assign o_active_mode = state;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  mode_switch_a: assert property (opm_wr && (i_par_wdata[15:0] == dvmc_pkg::OPMODE_SPEED_CTRL) // R1
    |=> state == dvmc_pkg::VM_SPEED) else $error("speed mode not entered after write");
  src_none_a: assert property (($past(state) == dvmc_pkg::VM_SPEED) // R3
    && ($past(speed_ref_source) == dvmc_pkg::SRC_NONE) |-> o_vel_cmd == 32'sh0)
    else $error("source none gave a nonzero command");
  speed_start_a: assert property (i_par_wr && (i_par_addr == dvmc_pkg::ADDR_SPEED_REF) // R4
    && spd_ok && (state == dvmc_pkg::VM_SPEED) && !stop_req |=> moving)
    else $error("speed reference write did not start movement");
  speed_direct_a: assert property ($past(state) == dvmc_pkg::VM_SPEED // R5
    |-> o_vel_cmd == $past(cmd_target)) else $error("speed command was ramped");
  speed_status_a: assert property ($past(state) != dvmc_pkg::VM_PROFILE // R7
    |-> o_drive_status_word == 16'h0000) else $error("status bits set outside profile");
  mode_leave_a: assert property (active && stop_req && !opm_wr // R8
    && (i_actual_velocity == 32'sh0) |=> state == dvmc_pkg::VM_IDLE)
    else $error("mode not left at standstill after stop");
  mode_hold_a: assert property (active && !stop_req && !opm_wr // R8
    |=> state == $past(state)) else $error("mode left without stop cause");
  ref_range_a: assert property (i_par_wr && (i_par_addr == dvmc_pkg::ADDR_SPEED_REF) // R9
    && !spd_ok |=> $stable(speed_ref_velocity)) else $error("out of range reference taken");
  speed_clamp_a: assert property ($past(state) == dvmc_pkg::VM_SPEED // R10
    |-> (o_vel_cmd <= $signed({16'h0000, $past(i_max_speed)}))
    && (o_vel_cmd >= -$signed({16'h0000, $past(i_max_speed)})))
    else $error("speed command above maximum speed");
  ramp_step_a: assert property ($past(state) == dvmc_pkg::VM_PROFILE // R11
    |-> (o_vel_cmd - $past(o_vel_cmd) <= $signed({16'h0000, RAMP_STEP_RPM}))
    && ($past(o_vel_cmd) - o_vel_cmd <= $signed({16'h0000, RAMP_STEP_RPM})))
    else $error("profile command stepped more than one ramp step");
  pv_start_a: assert property (i_par_wr && (i_par_addr == dvmc_pkg::ADDR_PROFILE_TARGET) // R12
    && (state == dvmc_pkg::VM_PROFILE) && !stop_req |=> moving)
    else $error("target write did not start movement");
  pv_reached_a: assert property (state == dvmc_pkg::VM_PROFILE // R13
    |=> o_drive_status_word[dvmc_pkg::STAT_REACHED_BIT] == ($past(i_actual_velocity)
    == $past(cmd_target))) else $error("target reached bit wrong");
  pv_zero_a: assert property (state == dvmc_pkg::VM_PROFILE // R14
    |=> o_drive_status_word[dvmc_pkg::STAT_ZERO_BIT] == ($past(i_actual_velocity) == 32'sh0))
    else $error("zero velocity bit wrong");

  speed_move_c: cover property ((state == dvmc_pkg::VM_SPEED) && (o_vel_cmd != 32'sh0));
  pv_reach_c: cover property (moving && o_drive_status_word[dvmc_pkg::STAT_REACHED_BIT]
    && (o_vel_cmd != 32'sh0));
  leave_c: cover property (active && stop_req ##1 state == dvmc_pkg::VM_IDLE);

endmodule

//--- src/dvmc_pkg.sv
// Purpose: shared constants for the drive velocity mode control block
// Assumes: 10 MHz system clock, parameters addressed by fieldbus word address
// Notes: velocities are in RPM
package dvmc_pkg;

  // ************************************************************
  // parameter addresses
  // ************************************************************
  localparam logic [15:0] ADDR_PROFILE_TARGET = 16'h1b1a;
  localparam logic [15:0] ADDR_SPEED_SOURCE = 16'h1b22;
  localparam logic [15:0] ADDR_SPEED_REF = 16'h2108;
  localparam logic [15:0] ADDR_OPMODE = 16'h1b26;
  localparam logic [15:0] ADDR_STATUS = 16'h1b28;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] RST_PROFILE_TARGET = 32'h0000_0000;
  localparam logic [15:0] RST_SPEED_SOURCE = 16'h0000;
  localparam logic [15:0] RST_SPEED_REF = 16'h0000;
  localparam logic [15:0] RST_OPMODE = 16'h0000;

  // ************************************************************
  // codes and limits
  // ************************************************************
  localparam logic [15:0] SRC_NONE = 16'h0000;
  localparam logic [15:0] SRC_PARAM = 16'h0002;
  localparam logic [15:0] OPMODE_PROFILE_VEL = 16'h0003;
  localparam logic [15:0] OPMODE_SPEED_CTRL = 16'hfffd;
  // -30000 and +30000 rpm as 16-bit two's complement
  localparam logic [15:0] SPEED_REF_MIN = 16'h8ad0;
  localparam logic [15:0] SPEED_REF_MAX = 16'h7530;
  localparam int STAT_REACHED_BIT = 10;
  localparam int STAT_ZERO_BIT = 12;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int RAMP_TICK_NS = 1000000;
  localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;
  localparam logic [15:0] RAMP_STEP_RPM = 16'h0010;

  typedef enum logic [1:0] {
    VM_IDLE = 2'b00,
    VM_SPEED = 2'b01,
    VM_PROFILE = 2'b10
  } dvmc_state_type;

endpackage

//--- src/dvmc_ramp.sv
// Purpose: velocity command generator, stepped ramp or direct follow
// Assumes: target magnitude well inside 32-bit range
// Notes: one step of STEP rpm per tick while ramping
`timescale 1ns/100ps
module dvmc_ramp #(
  parameter logic [15:0] STEP = dvmc_pkg::RAMP_STEP_RPM
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // control
  input wire logic i_tick,
  input wire logic i_bypass,
  input wire logic signed [31:0] i_target,
  // command
  output logic signed [31:0] o_vel
);

  logic signed [31:0] vel;
  logic signed [31:0] next_vel;
  logic signed [31:0] step;

  assign step = $signed({16'h0000, STEP});

  always_comb
  begin
    next_vel = vel;
    if (i_bypass)
      next_vel = i_target; // R5
    else if (i_tick)
    begin
      // never overshoot: the last step lands exactly on the target
      if (i_target - vel > step)
        next_vel = vel + step; // R11
      else if (vel - i_target > step)
        next_vel = vel - step; // R11
      else
        next_vel = i_target;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      vel <= 32'sh0000_0000;
    else
      vel <= next_vel;
  end

  assign o_vel = vel;

endmodule

//--- testbench/dvmc_master.sv
// Purpose: fieldbus master model issuing parameter reads and writes
// Assumes: one access per call, strobes change just after a rising edge
// Notes: released address and data are inverted so a stale value never looks valid
`timescale 1ns/100ps
module dvmc_master (
  // clock
  input wire logic i_sys_clk,
  // parameter port
  input wire logic [31:0] i_par_rdata,
  input wire logic i_par_rvalid,
  output logic o_par_wr,
  output logic o_par_rd,
  output logic [15:0] o_par_addr,
  output logic [31:0] o_par_wdata
);
  // ************************************************************
  // bus cycles
  // ************************************************************
  // no control word is driven from here, so its bits 4 to 6 stay zero
  initial
  begin
    o_par_wr = 1'b0;
    o_par_rd = 1'b0;
    o_par_addr = 16'h0000;
    o_par_wdata = 32'h0000_0000;
  end

  // every mode change and setpoint goes over this path, never a pin
  task automatic wr(input logic [15:0] addr, input logic [31:0] data);
    @(posedge i_sys_clk);
    o_par_wr <= 1'b1;
    o_par_addr <= addr;
    o_par_wdata <= data;
    @(posedge i_sys_clk);
    o_par_wr <= 1'b0;
    o_par_addr <= ~addr;
    o_par_wdata <= ~data;
  endtask

  task automatic rd(input logic [15:0] addr, output logic [31:0] data, output logic valid);
    @(posedge i_sys_clk);
    o_par_rd <= 1'b1;
    o_par_addr <= addr;
    @(posedge i_sys_clk);
    o_par_rd <= 1'b0;
    o_par_addr <= ~addr;
    #1;
    data = i_par_rdata;
    valid = i_par_rvalid;
  endtask
endmodule

//--- testbench/drive_velocity_mode_control_bench.sv
// Purpose: self-checking bench for the velocity mode block
// Assumes: short ramp tick so a full ramp fits in a few hundred cycles
// Notes: max speed 500 rpm except a 20 rpm spell in the profile test, ramp ceiling 40 rpm throughout
`timescale 1ns/100ps
module drive_velocity_mode_control_bench;
  localparam int TICK = 8;
  logic i_sys_clk;
  logic i_rst_b;
  logic [2:0] stop;
  logic par_wr;
  logic par_rd;
  logic [15:0] par_addr;
  logic [31:0] par_wdata;
  logic [31:0] par_rdata;
  logic par_rvalid;
  logic signed [31:0] act_vel;
  logic signed [31:0] vel_cmd;
  logic [15:0] max_speed;
  logic [15:0] ceiling;
  logic [15:0] status;
  logic [1:0] mode;
  int errors;
  int compares;

  dvmc_top #(.RAMP_TICK_CYCLES(TICK)) dvmc_top_i (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_par_wr(par_wr), .i_par_rd(par_rd),
    .i_par_addr(par_addr), .i_par_wdata(par_wdata), .o_par_rdata(par_rdata),
    .o_par_rvalid(par_rvalid), .i_halt(stop[0]), .i_quick_stop(stop[1]), .i_fault(stop[2]),
    .i_actual_velocity(act_vel), .i_max_speed(max_speed),
    .i_ramp_velocity_ceiling(ceiling), .o_vel_cmd(vel_cmd),
    .o_drive_status_word(status), .o_active_mode(mode)
  );

  dvmc_master dvmc_master_i (
    .i_sys_clk(i_sys_clk), .i_par_rdata(par_rdata), .i_par_rvalid(par_rvalid),
    .o_par_wr(par_wr), .o_par_rd(par_rd), .o_par_addr(par_addr), .o_par_wdata(par_wdata)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  initial
  begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic rd_chk(input logic [15:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    dvmc_master_i.rd(addr, d, v);
    check({31'h0, v}, 32'h1, "read valid");
    check(d, exp, "read data");
  endtask

  task automatic set_act(input logic signed [31:0] v);
    @(posedge i_sys_clk);
    act_vel <= v;
  endtask

  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rd_chk(dvmc_pkg::ADDR_PROFILE_TARGET, 32'h0);
    rd_chk(dvmc_pkg::ADDR_SPEED_SOURCE, 32'h0);
    rd_chk(dvmc_pkg::ADDR_SPEED_REF, 32'h0);
    rd_chk(16'h0000, 32'h0);
    check({30'h0, mode}, 32'h0, "idle after reset");
  endtask

  task automatic t_speed;
    set_act(32'sd500);
    dvmc_master_i.wr(dvmc_pkg::ADDR_OPMODE, {16'h0, dvmc_pkg::OPMODE_SPEED_CTRL});
    cycles(1);
    check({30'h0, mode}, 32'h1, "speed mode");
    dvmc_master_i.wr(dvmc_pkg::ADDR_SPEED_SOURCE, 32'h5);
    rd_chk(dvmc_pkg::ADDR_SPEED_SOURCE, 32'h0);
    // the source must name the parameter before a reference can move the motor
    dvmc_master_i.wr(dvmc_pkg::ADDR_SPEED_SOURCE, {16'h0, dvmc_pkg::SRC_PARAM});
    rd_chk(dvmc_pkg::ADDR_SPEED_SOURCE, 32'h2);
    dvmc_master_i.wr(dvmc_pkg::ADDR_SPEED_REF, 32'd1000);
    cycles(2);
    check(vel_cmd, 32'd500, "clamped step");
    check({16'h0, status}, 32'h0, "speed status");
    dvmc_master_i.wr(dvmc_pkg::ADDR_SPEED_REF, 32'h7531);
    rd_chk(dvmc_pkg::ADDR_SPEED_REF, 32'd1000);
    dvmc_master_i.wr(dvmc_pkg::ADDR_SPEED_REF, {16'h0, dvmc_pkg::SPEED_REF_MIN});
    rd_chk(dvmc_pkg::ADDR_SPEED_REF, {16'h0, dvmc_pkg::SPEED_REF_MIN});
    check(vel_cmd, -32'sd500, "negative clamp");
  endtask

  task automatic t_profile;
    // bring the speed command back to zero so the ramp starts from standstill
    dvmc_master_i.wr(dvmc_pkg::ADDR_SPEED_REF, 32'h0);
    set_act(32'sd0);
    dvmc_master_i.wr(dvmc_pkg::ADDR_OPMODE, {16'h0, dvmc_pkg::OPMODE_PROFILE_VEL});
    cycles(2);
    check({30'h0, mode}, 32'h2, "profile mode");
    dvmc_master_i.wr(dvmc_pkg::ADDR_PROFILE_TARGET, 32'd100);
    cycles(2);
    check({31'h0, vel_cmd >= 0 && vel_cmd <= 32'sd16}, 32'h1, "first ramp step");
    cycles(TICK * 6);
    check(vel_cmd, 32'd40, "ramp end clamp");
    rd_chk(dvmc_pkg::ADDR_PROFILE_TARGET, 32'd100);
    check({31'h0, status[10]}, 32'h0, "not reached");
    check({31'h0, status[12]}, 32'h1, "zero velocity");
    set_act(32'sd40);
    cycles(2);
    check({31'h0, status[10]}, 32'h1, "reached");
    check({31'h0, status[12]}, 32'h0, "moving");
    rd_chk(dvmc_pkg::ADDR_STATUS, 32'h0000_0400);
    rd_chk(dvmc_pkg::ADDR_OPMODE, {16'h0, dvmc_pkg::OPMODE_PROFILE_VEL});
    // a lower maximum speed must now win over the ramp ceiling
    @(posedge i_sys_clk);
    max_speed <= 16'h0014;
    cycles(TICK * 3);
    check(vel_cmd, 32'd20, "max speed clamp");
    @(posedge i_sys_clk);
    max_speed <= 16'h01f4;
    dvmc_master_i.wr(dvmc_pkg::ADDR_OPMODE, 32'h1);
    cycles(1);
    check({30'h0, mode}, 32'h0, "unknown code idles");
  endtask

  // each stop cause in turn; the mode must wait for standstill before it ends
  task automatic t_stop;
    for (int k = 0; k < 3; k++)
    begin
      dvmc_master_i.wr(dvmc_pkg::ADDR_OPMODE, {16'h0, dvmc_pkg::OPMODE_SPEED_CTRL});
      dvmc_master_i.wr(dvmc_pkg::ADDR_SPEED_REF, 32'd200);
      set_act(32'sd200);
      stop <= 3'(1 << k);
      cycles(4);
      check({30'h0, mode}, 32'h1, "held while moving");
      check(vel_cmd, 32'h0, "stop command");
      set_act(32'sd0);
      cycles(2);
      check({30'h0, mode}, 32'h0, "left at standstill");
      @(posedge i_sys_clk);
      stop <= 3'b000;
    end
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    errors = 0;
    compares = 0;
    i_rst_b = 1'b0;
    stop = 3'b000;
    act_vel = 32'sd0;
    max_speed = 16'h01f4;
    ceiling = 16'h0028;
    repeat (3) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    t_reset;
    t_speed;
    t_profile;
    t_stop;
    conclude;
  end

  // the whole run needs well under two thousand cycles
  initial
  begin
    #2000000;
    errors++;
    conclude;
  end
endmodule
